// ---- sim/tknj_core_tb.sv ----
// Purpose: Self-checking bench of the join control over APB
// Assumes: Zero-wait slave; own reconfig time shortened to 50 cycles
// Notes: Network stimulus comes from the partner model
`timescale 1ns/1ps
`include "tknj_cfg.svh"
module tknj_core_tb;
	import tknj_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	tknj_word_t pwdata = 32'h0;
	tknj_word_t prdata;
	tknj_word_t rd;
	logic pready, pslverr, err;
	logic act, tok, tok_me, dup, reconfiguration_flag, rx_done, rx_ok, tx_done, tx_ack;
	logic tx_line, tx_drive_en, rx_arm, tx_req, backplane, rx_all, rx_int;
	tknj_node_id_t node_id;
	logic tx_bit = 1'b1;
	int fail_count = 0;
	int tests_run = 0;
	always #25 clk = ~clk;
	tknj_core #(.OWN_RECONFIGURATION_FLAG_CYC(50)) u_dut (.core_clk_in(clk), .rst_in(rst),
		.psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
		.pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
		.net_rx_act_in(act), .net_token_in(tok), .net_token_me_in(tok_me),
		.net_dup_id_in(dup), .net_reconfiguration_flag_in(reconfiguration_flag), .net_rx_done_in(rx_done),
		.net_rx_ok_in(rx_ok), .net_tx_done_in(tx_done), .net_tx_ack_in(tx_ack),
		.tx_bit_in(tx_bit), .tx_line_out(tx_line), .tx_drive_en_out(tx_drive_en),
		.rx_arm_out(rx_arm), .tx_req_out(tx_req), .backplane_out(backplane),
		.rx_all_out(rx_all), .rx_int_out(rx_int), .node_id_out(node_id));
	tknj_net_model u_net (.clk_in(clk), .act_out(act), .tok_out(tok), .tok_me_out(tok_me),
		.dup_out(dup), .reconfiguration_flag_out(reconfiguration_flag), .rx_done_out(rx_done), .rx_ok_out(rx_ok),
		.tx_done_out(tx_done), .tx_ack_out(tx_ack));
	// ****************************************
	// Bus cycles and comparison
	// ****************************************
	task automatic apb(input logic wr, input logic [7:0] a, input tknj_word_t d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic chk(input string what, input tknj_word_t exp, input tknj_word_t got);
		tests_run++;
		if (got !== exp) begin
			$display("Error %s expected %h seen %h", what, exp, got);
			fail_count++;
		end
	endtask
	task automatic cmd(input tknj_word_t c, input int n);
		repeat (n) apb(1'b1, `TKNJ_OFS_CMD, c);
		repeat (3) @(posedge clk);
	endtask
	task automatic status_is(input string what, input logic [7:0] exp, input logic [7:0] m);
		apb(1'b0, `TKNJ_OFS_STATUS, 32'h0);
		chk(what, {24'h0, exp & m}, rd & {24'h0, m});
	endtask
	task automatic finish_test();
		$display("Checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		finish_test();
	end
	// ****************************************
	// Tests
	// ****************************************
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		chk("drive_en_rst", 32'h0, {31'h0, tx_drive_en});
		apb(1'b0, `TKNJ_OFS_CONFIG, 32'h0);
		chk("config_rst", 32'h0, rd);
		apb(1'b0, 8'h18, 32'h0);
		chk("unmapped_err", 32'h1, {31'h0, err});
		chk("unmapped_data", 32'h0, rd);
		$display("Test reset done");
		fork
			u_net.token_burst(8);
			begin
				repeat (10) @(posedge clk);
				apb(1'b0, `TKNJ_OFS_DIAG, 32'h0);
				repeat (130) @(posedge clk);
				apb(1'b0, `TKNJ_OFS_DIAG, 32'h0);
				chk("own_reconfiguration_flag_quiet", 32'h0, rd);
			end
		join
		repeat (60) @(posedge clk);
		apb(1'b0, `TKNJ_OFS_DIAG, 32'h0);
		chk("own_reconfiguration_flag_set", 32'h10, rd);
		apb(1'b1, `TKNJ_OFS_NODE, 32'hff);
		repeat (3) @(posedge clk);
		chk("node_first", 32'hff, {24'h0, node_id});
		$display("Test own reconfig done");
		u_net.levels(1'b1, 1'b1, 1'b0, 1'b0);
		repeat (10) @(posedge clk);
		u_net.levels(1'b0, 1'b0, 1'b0, 1'b0);
		repeat (5) @(posedge clk);
		apb(1'b0, `TKNJ_OFS_DIAG, 32'h0);
		chk("diag_healthy", 32'h6, rd & 32'hf);
		apb(1'b0, `TKNJ_OFS_DIAG, 32'h0);
		chk("diag_cleared", 32'h0, rd & 32'hf);
		u_net.levels(1'b0, 1'b0, 1'b1, 1'b1);
		repeat (10) @(posedge clk);
		u_net.levels(1'b0, 1'b0, 1'b0, 1'b0);
		repeat (5) @(posedge clk);
		apb(1'b0, `TKNJ_OFS_DIAG, 32'h0);
		chk("diag_dup_reconfiguration_flag", 32'h9, rd & 32'hf);
		apb(1'b1, `TKNJ_OFS_NODE, 32'hfe);
		repeat (3) @(posedge clk);
		chk("node_fetch", 32'hfe, {24'h0, node_id});
		$display("Test diagnostics done");
		chk("no_drive", 32'h0, {31'h0, tx_line});
		apb(1'b1, `TKNJ_OFS_CONFIG, 32'h5);
		repeat (3) @(posedge clk);
		chk("drive_en", 32'h1, {31'h0, tx_drive_en});
		chk("drive_line", 32'h1, {31'h0, tx_line});
		tx_bit <= 1'b0;
		repeat (2) @(posedge clk);
		chk("drive_line_low", 32'h0, {31'h0, tx_line});
		apb(1'b1, `TKNJ_OFS_MASK, 32'h1);
		cmd(32'h1, 3);
		cmd(32'h2, 3);
		status_is("chain_full", 8'ha0, 8'hf2);
		chk("tx_req", 32'h1, {31'h0, tx_req});
		u_net.done(1'b0, 1'b1);
		status_is("tx_ack_first", 8'h04, 8'h04);
		cmd(32'h8, 1);
		u_net.done(1'b0, 1'b0);
		status_is("tx_ack_second", 8'h40, 8'hc4);
		cmd(32'h8, 1);
		u_net.done(1'b1, 1'b1);
		chk("chain_rx_int", 32'h1, {31'h0, rx_int});
		u_net.done(1'b1, 1'b0);
		status_is("rx_two_done", 8'h29, 8'h39);
		cmd(32'h4, 1);
		status_is("rx_ok_second", 8'h11, 8'h39);
		cmd(32'h4, 1);
		chk("chain_rx_release", 32'h0, {31'h0, rx_int});
		status_is("chain_empty", 8'h02, 8'hf2);
		chk("idle_req", 32'h0, {30'h0, rx_arm, tx_req});
		$display("Test chained done");
		apb(1'b1, `TKNJ_OFS_CONFIG, 32'he);
		cmd(32'h2, 2);
		cmd(32'h1, 2);
		chk("mode_pins", 32'h3, {30'h0, backplane, rx_all});
		status_is("single_limit", 8'h50, 8'hf0);
		chk("rx_armed", 32'h1, {31'h0, rx_arm});
		chk("tx_armed", 32'h1, {31'h0, tx_req});
		u_net.done(1'b1, 1'b1);
		chk("single_rx_int", 32'h1, {31'h0, rx_int});
		cmd(32'h4, 1);
		chk("clear_ignored", 32'h1, {31'h0, rx_int});
		apb(1'b1, `TKNJ_OFS_MASK, 32'h0);
		repeat (3) @(posedge clk);
		chk("mask_release", 32'h0, {31'h0, rx_int});
		cmd(32'h2, 1);
		status_is("unch_reissue", 8'h10, 8'h31);
		$display("Test unchained done");
		finish_test();
	end
endmodule

// ---- sim/tknj_net_model.sv ----
// Purpose: Other nodes on the shared medium, as seen at the core's network pins
// Assumes: Driven from the bench clock; every change lands just after a rising edge
// Notes: Status lines show the inverse value once the done pulse has ended
`timescale 1ns/1ps
module tknj_net_model (
	input wire logic clk_in,
	output logic act_out,
	output logic tok_out,
	output logic tok_me_out,
	output logic dup_out,
	output logic reconfiguration_flag_out,
	output logic rx_done_out,
	output logic rx_ok_out,
	output logic tx_done_out,
	output logic tx_ack_out
);
	initial begin
		{act_out, tok_out, tok_me_out, dup_out, reconfiguration_flag_out} = 5'h0;
		{rx_done_out, rx_ok_out, tx_done_out, tx_ack_out} = 4'h0;
	end
	task automatic levels(input logic a, input logic t, input logic d, input logic r);
		@(posedge clk_in);
		act_out <= a;
		tok_out <= t;
		dup_out <= d;
		reconfiguration_flag_out <= r;
	endtask
	// Done pulses stay high and low for three cycles, above the two-stage synchroniser need
	task automatic done(input logic is_rx, input logic st);
		@(posedge clk_in);
		if (is_rx) begin
			rx_ok_out <= st;
			rx_done_out <= 1'b1;
		end else begin
			tx_ack_out <= st;
			tx_done_out <= 1'b1;
		end
		repeat (3) @(posedge clk_in);
		rx_done_out <= 1'b0;
		tx_done_out <= 1'b0;
		rx_ok_out <= ~rx_ok_out;
		tx_ack_out <= ~tx_ack_out;
		repeat (3) @(posedge clk_in);
	endtask
	task automatic token_burst(input int n);
		repeat (n) begin
			@(posedge clk_in);
			tok_me_out <= 1'b1;
			repeat (10) @(posedge clk_in);
			tok_me_out <= 1'b0;
			repeat (9) @(posedge clk_in);
		end
	endtask
endmodule

// ---- src/tknj_cfg.svh ----
// Purpose: Offsets, field positions, reset values and times of the join control
// Assumes: Included by its bare name; definitions only
// Notes: Offsets are byte addresses on the APB
`ifndef TKNJ_CFG_SVH
`define TKNJ_CFG_SVH
`define TKNJ_OFS_CONFIG 8'h00
`define TKNJ_OFS_NODE 8'h04
`define TKNJ_OFS_DIAG 8'h08
`define TKNJ_OFS_CMD 8'h0c
`define TKNJ_OFS_STATUS 8'h10
`define TKNJ_OFS_MASK 8'h14
`define TKNJ_CFG_CHAIN 0
`define TKNJ_CFG_BACKPL 1
`define TKNJ_CFG_TRANSMITTER_DRIVE_ENABLE 2
`define TKNJ_CFG_RXALL 3
`define TKNJ_CFG_W 4
`define TKNJ_CFG_RST 4'h0
`define TKNJ_NODE_RST 8'h00
`define TKNJ_MASK_RST 1'h0
`define TKNJ_CMD_TX 0
`define TKNJ_CMD_RX 1
`define TKNJ_CMD_CLR_RX 2
`define TKNJ_CMD_CLR_TX 3
`define TKNJ_DIAG_W 5
`define TKNJ_CLK_KHZ 20000
`define TKNJ_OWN_RECONFIGURATION_FLAG_MS 840
`define TKNJ_FETCH_US 52
`endif

// ---- src/tknj_cmdq.sv ----
// Purpose: Queue of outstanding commands with a status copy per entry
// Assumes: Entries complete in the order they were issued
// Notes: Depth limit drops to one when chaining is off
`timescale 1ns/1ps
module tknj_cmdq #(
	parameter int DEPTH = 2,
	parameter int SW = 1,
	parameter int CW = 2
) (
	input wire logic clk_in,
	input wire logic rst_in,
	tknj_cmdq_if.q q_if
);
	import tknj_pkg::*;
	logic [CW-1:0] count_reg;
	logic [CW-1:0] done_reg;
	logic [SW-1:0] stat_reg [DEPTH];
	wire [SW-1:0] stat_next [DEPTH];
	wire [CW-1:0] limit;
	wire [CW-1:0] widx;
	wire rel;
	wire acc;
	wire cmpl;
	assign limit = q_if.chained ? CW'(DEPTH) : CW'(1);
	assign q_if.full = count_reg >= limit;
	assign q_if.head_done = done_reg != '0;
	assign q_if.pend = count_reg > done_reg;
	assign q_if.head_stat = stat_reg[0];
	assign q_if.count = count_reg;
	// Unchained: a clear command is ignored, the next issue replaces the done entry
	assign rel = q_if.head_done & (q_if.chained ? q_if.release_cmd : (q_if.push & q_if.full));
	assign acc = q_if.push & (!q_if.full | rel);
	assign cmpl = q_if.complete & q_if.pend;
	assign widx = rel ? done_reg - CW'(1) : done_reg;
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			count_reg <= '0;
			done_reg <= '0;
		end else begin
			count_reg <= count_reg + CW'(acc) - CW'(rel);
			done_reg <= done_reg + CW'(cmpl) - CW'(rel);
		end
	end
	genvar i;
	generate
		for (i = 0; i < DEPTH; i++) begin : g_ent
			wire [SW-1:0] up;
			if (i + 1 < DEPTH) begin : g_mid
				assign up = stat_reg[i+1];
			end else begin : g_last
				assign up = '0;
			end
			// Each finished command keeps its own status until released
			assign stat_next[i] = (cmpl && widx == CW'(i)) ? q_if.cstat : (rel ? up : stat_reg[i]);
			always_ff @(posedge clk_in or posedge rst_in) begin
				if (rst_in) begin
					stat_reg[i] <= '0;
				end else begin
					stat_reg[i] <= stat_next[i];
				end
			end
		end
	endgenerate
	// ****************************************
	// Checks
	// ****************************************
	property p_depth_bound;
		@(posedge clk_in) disable iff (rst_in)
		(q_if.chained || count_reg <= CW'(1)) |-> count_reg <= limit;
	endproperty
	a_depth_bound: assert property (p_depth_bound) else $error("queue above limit");
	property p_stat_copy;
		@(posedge clk_in) disable iff (rst_in)
		(q_if.chained && cmpl && !rel && done_reg == CW'(1)) |=>
			(stat_reg[1] == $past(q_if.cstat) && stat_reg[0] == $past(stat_reg[0]));
	endproperty
	a_stat_copy: assert property (p_stat_copy) else $error("status copy lost");
endmodule

// ---- src/tknj_cmdq_if.sv ----
// Purpose: Signals between the core and one command queue
// Assumes: One instance per direction (transmit, receive)
// Notes: CW must fit the queue depth
`timescale 1ns/1ps
interface tknj_cmdq_if #(parameter int CW = 2, parameter int SW = 1);
	logic chained;
	logic push;
	logic complete;
	logic release_cmd;
	logic [SW-1:0] cstat;
	logic pend;
	logic full;
	logic head_done;
	logic [SW-1:0] head_stat;
	logic [CW-1:0] count;
	modport ctl(output chained, push, complete, release_cmd, cstat,
		input pend, full, head_done, head_stat, count);
	modport q(input chained, push, complete, release_cmd, cstat,
		output pend, full, head_done, head_stat, count);
endinterface

// ---- src/tknj_core.sv ----
// Purpose: Command queues, diagnostics and network join control of a token bus node
// Assumes: APB slave, zero wait states; network inputs are asynchronous pins
// Notes: Host runs the join and id search; the core supplies flags and gating
//
// Functional notes
// - Chained mode holds two transmit, two receive commands
// - Unchained mode holds one command per direction
// - Chained mode keeps status per queued command
// - Reading diagnostics clears latched diagnostic bits
// - Transmitter drives only after drive enable written
// - Unchained receive interrupt released by mask or by the next receive command, not by clear
// - Chained clear command releases receive interrupt
// - New node id fetched within 52 us
// - Own reconfig set after 840 ms without own token
//
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "tknj_cfg.svh"
module tknj_core #(
	parameter int AW = 8,
	parameter int QDEPTH = 2,
	parameter int OWN_RECONFIGURATION_FLAG_CYC = `TKNJ_OWN_RECONFIGURATION_FLAG_MS * `TKNJ_CLK_KHZ
) (
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [AW-1:0] paddr_in,
	input wire tknj_pkg::tknj_word_t pwdata_in,
	output tknj_pkg::tknj_word_t prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire logic net_rx_act_in,
	input wire logic net_token_in,
	input wire logic net_token_me_in,
	input wire logic net_dup_id_in,
	input wire logic net_reconfiguration_flag_in,
	input wire logic net_rx_done_in,
	input wire logic net_rx_ok_in,
	input wire logic net_tx_done_in,
	input wire logic net_tx_ack_in,
	input wire logic tx_bit_in,
	output logic tx_line_out,
	output logic tx_drive_en_out,
	output logic rx_arm_out,
	output logic tx_req_out,
	output logic backplane_out,
	output logic rx_all_out,
	output logic rx_int_out,
	output tknj_pkg::tknj_node_id_t node_id_out
);
	import tknj_pkg::*;
	localparam int FETCH_CYC = `TKNJ_FETCH_US * `TKNJ_CLK_KHZ / 1000;
	localparam int FW = $clog2(FETCH_CYC + 1);
	localparam int TW = $clog2(OWN_RECONFIGURATION_FLAG_CYC);
	localparam int QCW = $clog2(QDEPTH + 1);
	localparam int NS = 9;
	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [NS-1:0] s1_reg;
	logic [NS-1:0] s2_reg;
	logic [NS-1:0] s3_reg;
	wire [NS-1:0] pins = {net_tx_ack_in, net_tx_done_in, net_rx_ok_in, net_rx_done_in,
		net_reconfiguration_flag_in, net_dup_id_in, net_token_me_in, net_token_in, net_rx_act_in};
	wire me_p = s2_reg[2] & ~s3_reg[2];
	wire rxd_p = s2_reg[5] & ~s3_reg[5];
	wire txd_p = s2_reg[7] & ~s3_reg[7];
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
		end else begin
			s1_reg <= pins;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end
	// ****************************************
	// APB decode
	// ****************************************
	logic [`TKNJ_CFG_W-1:0] cfg_reg;
	tknj_node_id_t node_id_reg;
	tknj_node_id_t node_act_reg;
	tknj_diag_t diag_reg;
	logic mask_reg;
	tknj_word_t prdata_reg;
	logic pslverr_reg;
	tknj_cmdq_if #(.CW(QCW), .SW(1)) rxq_if();
	tknj_cmdq_if #(.CW(QCW), .SW(1)) txq_if();
	wire setup = psel_in & ~penable_in;
	wire acc_wr = psel_in & penable_in & pwrite_in;
	wire acc_rd = psel_in & penable_in & ~pwrite_in;
	wire hit_cfg = paddr_in == AW'(`TKNJ_OFS_CONFIG);
	wire hit_node = paddr_in == AW'(`TKNJ_OFS_NODE);
	wire hit_diag = paddr_in == AW'(`TKNJ_OFS_DIAG);
	wire hit_cmd = paddr_in == AW'(`TKNJ_OFS_CMD);
	wire hit_stat = paddr_in == AW'(`TKNJ_OFS_STATUS);
	wire hit_mask = paddr_in == AW'(`TKNJ_OFS_MASK);
	wire mapped = hit_cfg | hit_node | hit_diag | hit_cmd | hit_stat | hit_mask;
	wire wr_cfg = acc_wr & hit_cfg;
	wire wr_node = acc_wr & hit_node;
	wire wr_mask = acc_wr & hit_mask;
	wire wr_cmd = acc_wr & hit_cmd;
	wire rd_diag = acc_rd & hit_diag;
	wire cmd_tx = wr_cmd & pwdata_in[`TKNJ_CMD_TX];
	wire cmd_rx = wr_cmd & pwdata_in[`TKNJ_CMD_RX];
	wire cmd_clr_rx = wr_cmd & pwdata_in[`TKNJ_CMD_CLR_RX];
	wire cmd_clr_tx = wr_cmd & pwdata_in[`TKNJ_CMD_CLR_TX];
	wire chained = cfg_reg[`TKNJ_CFG_CHAIN];
	wire transmitter_drive_enable = cfg_reg[`TKNJ_CFG_TRANSMITTER_DRIVE_ENABLE];
	wire [31:0] stat_word = 32'({txq_if.count, rxq_if.count, rxq_if.head_stat,
		txq_if.head_stat, ~txq_if.full, rxq_if.head_done});
	wire [31:0] rd_data = hit_cfg ? 32'(cfg_reg) : hit_node ? 32'(node_id_reg) :
		hit_diag ? 32'(diag_reg) : hit_stat ? stat_word : hit_mask ? 32'(mask_reg) : 32'h0;
	// ****************************************
	// Diagnostics and own reconfig timer
	// ****************************************
	logic [TW-1:0] timer_reg;
	wire tmr_end = timer_reg == TW'(OWN_RECONFIGURATION_FLAG_CYC - 1);
	wire own_p = tmr_end & ~me_p;
	tknj_diag_t diag_set;
	wire [`TKNJ_DIAG_W-1:0] diag_clr = rd_diag ? prdata_reg[`TKNJ_DIAG_W-1:0] : '0;
	assign diag_set = {own_p, s2_reg[4], s2_reg[1], s2_reg[0], s2_reg[3]};
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			timer_reg <= '0;
			diag_reg <= '0;
		end else begin
			timer_reg <= (me_p | tmr_end) ? '0 : timer_reg + TW'(1);
			// Only bits the host actually saw are cleared, and a new event wins
			diag_reg <= (diag_reg & ~diag_clr) | diag_set;
		end
	end
	// ****************************************
	// Registers and outputs
	// ****************************************
	// Changing the chain mode with commands queued leaves them in place
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			cfg_reg <= `TKNJ_CFG_RST;
			node_id_reg <= `TKNJ_NODE_RST;
			node_act_reg <= `TKNJ_NODE_RST;
			mask_reg <= `TKNJ_MASK_RST;
		end else begin
			cfg_reg <= wr_cfg ? pwdata_in[`TKNJ_CFG_W-1:0] : cfg_reg;
			node_id_reg <= wr_node ? pwdata_in[7:0] : node_id_reg;
			node_act_reg <= node_id_reg;
			mask_reg <= wr_mask ? pwdata_in[0] : mask_reg;
		end
	end
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			prdata_reg <= '0;
			pslverr_reg <= 1'b0;
			tx_drive_en_out <= 1'b0;
			tx_line_out <= 1'b0;
			rx_int_out <= 1'b0;
		end else begin
			prdata_reg <= setup ? rd_data : prdata_reg;
			pslverr_reg <= setup ? ~mapped : pslverr_reg;
			tx_drive_en_out <= transmitter_drive_enable;
			tx_line_out <= transmitter_drive_enable & tx_bit_in;
			rx_int_out <= mask_reg & rxq_if.head_done;
		end
	end
	assign prdata_out = prdata_reg;
	assign pslverr_out = pslverr_reg;
	assign pready_out = 1'b1;
	assign node_id_out = node_act_reg;
	// Lag of the fetched id behind the written one; the window is too long for a delay range
	logic [FW-1:0] fetch_wait_reg;
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			fetch_wait_reg <= '0;
		end else begin
			fetch_wait_reg <= (node_id_out != node_id_reg) ? fetch_wait_reg + FW'(1) : '0;
		end
	end
	assign backplane_out = cfg_reg[`TKNJ_CFG_BACKPL];
	assign rx_all_out = cfg_reg[`TKNJ_CFG_RXALL];
	assign rx_arm_out = rxq_if.pend;
	assign tx_req_out = txq_if.pend;
	// ****************************************
	// Command queues
	// ****************************************
	assign rxq_if.chained = chained;
	assign rxq_if.push = cmd_rx;
	assign rxq_if.complete = rxd_p;
	assign rxq_if.release_cmd = cmd_clr_rx;
	assign rxq_if.cstat = s2_reg[6];
	assign txq_if.chained = chained;
	assign txq_if.push = cmd_tx;
	assign txq_if.complete = txd_p;
	assign txq_if.release_cmd = cmd_clr_tx;
	assign txq_if.cstat = s2_reg[8];
	tknj_cmdq #(.DEPTH(QDEPTH), .SW(1), .CW(QCW)) u_rxq (
		.clk_in(core_clk_in),
		.rst_in(rst_in),
		.q_if(rxq_if)
	);
	tknj_cmdq #(.DEPTH(QDEPTH), .SW(1), .CW(QCW)) u_txq (
		.clk_in(core_clk_in),
		.rst_in(rst_in),
		.q_if(txq_if)
	);
	// ****************************************
	// Checks
	// ****************************************
	property p_diag_clear;
		@(posedge core_clk_in) disable iff (rst_in)
		(rd_diag && diag_set == '0) |=> ((diag_reg & $past(diag_clr)) == '0);
	endproperty
	a_diag_clear: assert property (p_diag_clear) else $error("diag not cleared");
	property p_diag_set_wins;
		@(posedge core_clk_in) disable iff (rst_in)
		(diag_set != '0) |=> ((diag_reg & $past(diag_set)) == $past(diag_set));
	endproperty
	a_diag_set_wins: assert property (p_diag_set_wins) else $error("diag event lost");
	property p_tx_gate;
		@(posedge core_clk_in) disable iff (rst_in)
		!transmitter_drive_enable |=> (!tx_drive_en_out && !tx_line_out);
	endproperty
	a_tx_gate: assert property (p_tx_gate) else $error("drive without enable");
	sequence s_transmitter_drive_enable_on;
		wr_cfg && pwdata_in[`TKNJ_CFG_TRANSMITTER_DRIVE_ENABLE] ##1 transmitter_drive_enable;
	endsequence
	property p_tx_follow;
		@(posedge core_clk_in) disable iff (rst_in)
		s_transmitter_drive_enable_on |=> tx_drive_en_out;
	endproperty
	a_tx_follow: assert property (p_tx_follow) else $error("drive enable late");
	property p_unch_hold;
		@(posedge core_clk_in) disable iff (rst_in)
		(!chained && cmd_clr_rx && !cmd_rx && rxq_if.head_done) |=> rxq_if.head_done;
	endproperty
	a_unch_hold: assert property (p_unch_hold) else $error("unchained clear acted");
	property p_ch_release;
		@(posedge core_clk_in) disable iff (rst_in)
		(chained && cmd_clr_rx && !cmd_rx && rxq_if.head_done) |=>
			(rxq_if.count == QCW'($past(rxq_if.count) - 1));
	endproperty
	a_ch_release: assert property (p_ch_release) else $error("clear did not release");
	property p_fetch;
		@(posedge core_clk_in) disable iff (rst_in)
		(node_id_out != node_id_reg) |-> (fetch_wait_reg < FW'(FETCH_CYC));
	endproperty
	a_fetch: assert property (p_fetch) else $error("node id not fetched");
	property p_own_reconfiguration_flag;
		@(posedge core_clk_in) disable iff (rst_in)
		(!diag_reg.own_reconfiguration_flag ##1 diag_reg.own_reconfiguration_flag) |-> $past(tmr_end) && !$past(me_p);
	endproperty
	a_own_reconfiguration_flag: assert property (p_own_reconfiguration_flag) else $error("own reconfig early");
	property p_timer_clear;
		@(posedge core_clk_in) disable iff (rst_in)
		me_p |=> (timer_reg == '0 && !diag_set.own_reconfiguration_flag);
	endproperty
	a_timer_clear: assert property (p_timer_clear) else $error("timer not restarted");
endmodule

// ---- src/tknj_pkg.sv ----
// Purpose: Types shared by the join control files
// Assumes: Constants live in tknj_cfg.svh
// Notes: Diagnostic struct order matches the diagnostic register bits
package tknj_pkg;
	typedef logic [7:0] tknj_node_id_t;
	typedef logic [31:0] tknj_word_t;
	typedef struct packed {
		logic own_reconfiguration_flag;
		logic reconfiguration_flag;
		logic token;
		logic act;
		logic dup;
	} tknj_diag_t;
endpackage
